// ### pkg/incdec_defs.svh
// Constants for the increment/decrement and flash instruction unit
`ifndef INCDEC_DEFS_SVH
`define INCDEC_DEFS_SVH

// Opcode fields
`define INCDEC_OPC_HI 15
`define INCDEC_OPC_LO 9
`define INCDEC_FADDR_HI 8
`define INCDEC_OPC_DECSZ_FR 7'h17
`define INCDEC_OPC_DECSZ_W 7'h16
`define INCDEC_OPC_INC_FR 7'h15
`define INCDEC_OPC_INC_W 7'h14
`define INCDEC_OPC_INCSNZ_FR 7'h2d
`define INCDEC_OPC_INCSNZ_W 7'h2c
`define INCDEC_OPC_ERASE 16'h0003
`define INCDEC_OPC_FREAD 16'h001b
`define INCDEC_OPC_FPROG 16'h001a

// Flash window defaults
`define INCDEC_FLASH_LO 24'h000000
`define INCDEC_FLASH_HI 24'h01ffff

// Register byte offsets
`define INCDEC_REG_ACC 12'h000
`define INCDEC_REG_STATUS 12'h004
`define INCDEC_REG_PTR 12'h008
`define INCDEC_REG_DATA 12'h00c
`define INCDEC_REG_XSET 12'h010
`define INCDEC_REG_ISTAT 12'h014
`define INCDEC_REG_IMASK 12'h018
`define INCDEC_REG_PC 12'h01c
`define INCDEC_MEM_SEL_BIT 11

// Field positions and widths
`define INCDEC_ZERO_BIT 0
`define INCDEC_PEND_BIT 0
`define INCDEC_EV_DONE 0
`define INCDEC_EV_REFUSED 1
`define INCDEC_EV_SKIP 2
`define INCDEC_EV_W 3

// Reset values
`define INCDEC_RST_BYTE 8'h00
`define INCDEC_RST_WORD 16'h0000
`define INCDEC_RST_PTR 24'h000000
`define INCDEC_RST_EV 3'h0
`define INCDEC_RST_BUS 32'h0000_0000

`endif

// ### pkg/incdec_pkg.sv
// Types for the increment/decrement and flash instruction unit
package incdec_pkg;

    typedef enum logic [1:0] {
        INCDEC_S_RUN = 2'b00,
        INCDEC_S_DROP = 2'b01,
        INCDEC_S_STALL = 2'b10
    } incdec_state_t;

    typedef enum logic [3:0] {
        INCDEC_C_NONE = 4'b0000,
        INCDEC_C_DECSZ_FR = 4'b0001,
        INCDEC_C_DECSZ_W = 4'b0010,
        INCDEC_C_INC_FR = 4'b0011,
        INCDEC_C_INC_W = 4'b0100,
        INCDEC_C_INCSNZ_FR = 4'b0101,
        INCDEC_C_INCSNZ_W = 4'b0110,
        INCDEC_C_ERASE = 4'b0111,
        INCDEC_C_FREAD = 4'b1000,
        INCDEC_C_FPROG = 4'b1001
    } incdec_class_t;

    typedef enum logic [1:0] {
        INCDEC_F_ERASE = 2'b00,
        INCDEC_F_READ = 2'b01,
        INCDEC_F_PROG = 2'b10
    } incdec_fop_t;

endpackage : incdec_pkg

// ### rtl/incdec_core.sv
// Increment/decrement skip instructions and non-blocking flash operations
// Notes on behaviour
// - Decrement-to-memory: write byte minus one back, skip next if zero, flags kept.
// - Decrement-to-memory takes one cycle, or three when it skips.
// - Decrement-to-accumulator: memory kept, skip if zero, flags kept.
// - Accumulator decrement and both increment-skip forms: one cycle, two when skipping.
// - Erase opcode starts a 512-byte block erase, byte address 15:8 from middle pointer.
// - Flash erase, read or program outside the flash window is not issued; it only sets the refused event.
// - Flash ops issue in one cycle, set pending, core continues, done clears.
// - While pending, no fetch from flash; flash ops run from program RAM.
// - Flash read loads the 16-bit word at the 24-bit pointer into data bytes.
// - Flash program writes the 16-bit data bytes at the 24-bit pointer.
// - Increment-to-memory in one cycle; zero flag set on wrap to zero.
// - Increment-to-accumulator in one cycle; memory kept; zero flag on zero.
// - Increment-to-memory, skip next if nonzero, flags kept.
// - Increment-to-accumulator, memory kept, skip next if nonzero, flags kept.
`timescale 1ns/1ps
`include "incdec_defs.svh"

module incdec_core import incdec_pkg::*; #(
    parameter logic [23:0] FLASH_LO = `INCDEC_FLASH_LO,
    parameter logic [23:0] FLASH_HI = `INCDEC_FLASH_HI
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_in,
    input wire logic from_flash_in,
    output logic instr_ready_out,
    output logic [15:0] pc_out,
    output logic [7:0] acc_out,
    output logic zero_flag_out,
    output logic flash_op_pending_out,
    output logic flash_req_out,
    output logic [1:0] flash_op_out,
    output logic [23:0] flash_addr_out,
    output logic [15:0] flash_wdata_out,
    input wire logic flash_done_in,
    input wire logic [15:0] flash_rdata_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq_out
);

    if (FLASH_LO > FLASH_HI) begin : g_bad_window
        $error("incdec_core: flash window bounds reversed");
    end

    function automatic incdec_class_t decode(input logic [15:0] w);
        logic [6:0] top;
        top = w[`INCDEC_OPC_HI:`INCDEC_OPC_LO];
        if (w == `INCDEC_OPC_ERASE) return INCDEC_C_ERASE;
        else if (w == `INCDEC_OPC_FREAD) return INCDEC_C_FREAD;
        else if (w == `INCDEC_OPC_FPROG) return INCDEC_C_FPROG;
        else if (top == `INCDEC_OPC_DECSZ_FR) return INCDEC_C_DECSZ_FR;
        else if (top == `INCDEC_OPC_DECSZ_W) return INCDEC_C_DECSZ_W;
        else if (top == `INCDEC_OPC_INC_FR) return INCDEC_C_INC_FR;
        else if (top == `INCDEC_OPC_INC_W) return INCDEC_C_INC_W;
        else if (top == `INCDEC_OPC_INCSNZ_FR) return INCDEC_C_INCSNZ_FR;
        else if (top == `INCDEC_OPC_INCSNZ_W) return INCDEC_C_INCSNZ_W;
        else return INCDEC_C_NONE;
    endfunction : decode

    function automatic logic in_flash(input logic [23:0] a);
        return (a >= FLASH_LO) && (a <= FLASH_HI);
    endfunction : in_flash

    logic [7:0] dmem [512];
    incdec_state_t state_q, state_d;
    logic ready_q, ready_d;
    logic long_q;
    logic [15:0] pc_q;
    logic [7:0] acc_q, acc_d;
    logic zero_q, zero_d;
    logic [23:0] ptr_q, ptr_d;
    logic [15:0] data_q, data_d;
    logic pend_q, pend_d;
    logic rd_op_q;
    logic freq_q;
    logic [1:0] fop_q;
    logic [23:0] faddr_q;
    logic [15:0] fwdata_q;
    logic [2:0] istat_q, istat_d, imask_q, imask_d;
    logic irq_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;

    // Instruction decode and datapath
    wire accept = instr_valid_in && ready_q;
    wire exec = accept && (state_q == INCDEC_S_RUN);
    wire drop = accept && (state_q == INCDEC_S_DROP);
    wire incdec_class_t cls = decode(instr_in);
    wire [8:0] maddr = instr_in[`INCDEC_FADDR_HI:0];
    wire [7:0] mval = dmem[maddr];
    wire is_dec = (cls == INCDEC_C_DECSZ_FR) || (cls == INCDEC_C_DECSZ_W);
    wire [7:0] result = is_dec ? 8'(mval - 8'h01) : 8'(mval + 8'h01);
    wire res_zero = (result == 8'h00);
    wire skip_zero = is_dec;
    wire skip_nz = (cls == INCDEC_C_INCSNZ_FR) || (cls == INCDEC_C_INCSNZ_W);
    wire skip = exec && ((skip_zero && res_zero) || (skip_nz && !res_zero));
    wire mem_we = exec && ((cls == INCDEC_C_DECSZ_FR) || (cls == INCDEC_C_INC_FR)
        || (cls == INCDEC_C_INCSNZ_FR));
    wire acc_we = exec && ((cls == INCDEC_C_DECSZ_W) || (cls == INCDEC_C_INC_W)
        || (cls == INCDEC_C_INCSNZ_W));
    wire z_we = exec && ((cls == INCDEC_C_INC_FR) || (cls == INCDEC_C_INC_W));

    // Flash command issue
    wire fl_cmd = exec && ((cls == INCDEC_C_ERASE) || (cls == INCDEC_C_FREAD)
        || (cls == INCDEC_C_FPROG));
    wire [23:0] fl_addr = (cls == INCDEC_C_ERASE) ? {ptr_q[23:8], 8'h00} : ptr_q;
    wire fl_go = fl_cmd && in_flash(fl_addr) && !pend_q;
    wire fl_refused = fl_cmd && !fl_go;
    wire fl_done = pend_q && flash_done_in;
    wire incdec_fop_t fop = (cls == INCDEC_C_ERASE) ? INCDEC_F_ERASE
        : (cls == INCDEC_C_FREAD) ? INCDEC_F_READ : INCDEC_F_PROG;

    // APB decode
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite && pready_q;
    wire mem_sel = paddr[`INCDEC_MEM_SEL_BIT];
    wire [8:0] apb_maddr = paddr[10:2];
    wire hit_acc = (paddr == `INCDEC_REG_ACC);
    wire hit_status = (paddr == `INCDEC_REG_STATUS);
    wire hit_ptr = (paddr == `INCDEC_REG_PTR);
    wire hit_data = (paddr == `INCDEC_REG_DATA);
    wire hit_xset = (paddr == `INCDEC_REG_XSET);
    wire hit_istat = (paddr == `INCDEC_REG_ISTAT);
    wire hit_imask = (paddr == `INCDEC_REG_IMASK);
    wire hit_pc = (paddr == `INCDEC_REG_PC);
    wire aligned = (paddr[1:0] == 2'b00);
    wire mapped = aligned && (mem_sel || hit_acc || hit_status || hit_ptr || hit_data
        || hit_xset || hit_istat || hit_imask || hit_pc);
    wire [31:0] rd_mux = !aligned ? `INCDEC_RST_BUS
        : mem_sel ? {24'h000000, dmem[apb_maddr]}
        : hit_acc ? {24'h000000, acc_q}
        : hit_status ? {31'h0, zero_q}
        : hit_ptr ? {8'h00, ptr_q}
        : hit_data ? {16'h0000, data_q}
        : hit_xset ? {31'h0, pend_q}
        : hit_istat ? {29'h0, istat_q}
        : hit_imask ? {29'h0, imask_q}
        : hit_pc ? {16'h0000, pc_q}
        : `INCDEC_RST_BUS;
    wire apb_mem_we = apb_wr && mapped && mem_sel && !mem_we;
    wire [2:0] events = {skip, fl_refused, fl_done};

    // Next values
    always_comb begin
        state_d = state_q;
        case (state_q)
            INCDEC_S_RUN: begin
                if (skip) state_d = INCDEC_S_DROP;
            end
            INCDEC_S_DROP: begin
                if (drop) state_d = long_q ? INCDEC_S_STALL : INCDEC_S_RUN;
            end
            INCDEC_S_STALL: begin
                state_d = INCDEC_S_RUN;
            end
            default: begin
                state_d = INCDEC_S_RUN;
            end
        endcase
    end

    assign pend_d = fl_go || (pend_q && !flash_done_in);
    assign ready_d = (state_d != INCDEC_S_STALL) && !(pend_d && from_flash_in);
    assign acc_d = acc_we ? result
        : (apb_wr && hit_acc) ? pwdata[7:0] : acc_q;
    assign zero_d = z_we ? res_zero
        : (apb_wr && hit_status) ? pwdata[`INCDEC_ZERO_BIT] : zero_q;
    assign ptr_d = (apb_wr && hit_ptr) ? pwdata[23:0] : ptr_q;
    assign data_d = (fl_done && rd_op_q) ? flash_rdata_in
        : (apb_wr && hit_data) ? pwdata[15:0] : data_q;
    assign istat_d = events | (istat_q & ~((apb_wr && hit_istat) ? pwdata[2:0] : 3'h0));
    assign imask_d = (apb_wr && hit_imask) ? pwdata[2:0] : imask_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= INCDEC_S_RUN;
            ready_q <= 1'b0;
            long_q <= 1'b0;
            pc_q <= `INCDEC_RST_WORD;
        end else begin
            state_q <= state_d;
            ready_q <= ready_d;
            if (skip) long_q <= (cls == INCDEC_C_DECSZ_FR);
            if (accept) pc_q <= 16'(pc_q + 16'h0001);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_q <= `INCDEC_RST_BYTE;
            zero_q <= 1'b0;
            ptr_q <= `INCDEC_RST_PTR;
            data_q <= `INCDEC_RST_WORD;
            istat_q <= `INCDEC_RST_EV;
            imask_q <= `INCDEC_RST_EV;
            irq_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            zero_q <= zero_d;
            ptr_q <= ptr_d;
            data_q <= data_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
            irq_q <= |(istat_d & imask_d);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= 1'b0;
            rd_op_q <= 1'b0;
            freq_q <= 1'b0;
            fop_q <= INCDEC_F_ERASE;
            faddr_q <= `INCDEC_RST_PTR;
            fwdata_q <= `INCDEC_RST_WORD;
        end else begin
            pend_q <= pend_d;
            freq_q <= fl_go;
            if (fl_go) begin
                rd_op_q <= (fop == INCDEC_F_READ);
                fop_q <= fop;
                faddr_q <= fl_addr;
                fwdata_q <= data_q;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `INCDEC_RST_BUS;
        end else begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup && !mapped;
            if (apb_setup) prdata_q <= pwrite ? `INCDEC_RST_BUS : rd_mux;
        end
    end

    always_ff @(posedge clk_in) begin
        if (mem_we) dmem[maddr] <= result;
        else if (apb_mem_we) dmem[apb_maddr] <= pwdata[7:0];
    end

    assign instr_ready_out = ready_q;
    assign pc_out = pc_q;
    assign acc_out = acc_q;
    assign zero_flag_out = zero_q;
    assign flash_op_pending_out = pend_q;
    assign flash_req_out = freq_q;
    assign flash_op_out = fop_q;
    assign flash_addr_out = faddr_q;
    assign flash_wdata_out = fwdata_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq_out = irq_q;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_dec_mem_back: assert property (
        exec && cls == INCDEC_C_DECSZ_FR |=> dmem[$past(maddr)] == 8'($past(mval) - 8'h01))
        else $error("decrement result not written back");
    a_long_skip_time: assert property (
        exec && cls == INCDEC_C_DECSZ_FR && res_zero ##1 drop
        |=> state_q == INCDEC_S_STALL ##1 state_q == INCDEC_S_RUN)
        else $error("memory decrement skip not three cycles");
    a_acc_dest_mem: assert property (
        acc_we |=> acc_out == $past(result) && dmem[$past(maddr)] == $past(mval))
        else $error("accumulator form touched memory or lost result");
    a_short_skip_time: assert property (
        skip && cls != INCDEC_C_DECSZ_FR ##1 drop |=> state_q == INCDEC_S_RUN)
        else $error("short skip took more than two cycles");
    a_skip_flags_kept: assert property (
        exec && (skip_zero || skip_nz) |=> $stable(zero_flag_out))
        else $error("skip instruction changed the zero flag");
    a_erase_block_addr: assert property (
        fl_go && cls == INCDEC_C_ERASE |=> flash_addr_out[7:0] == 8'h00
            && flash_addr_out[15:8] == $past(ptr_q[15:8]))
        else $error("erase block address wrong");
    a_range_no_op: assert property (
        fl_cmd && !in_flash(fl_addr) |=> !flash_req_out && $stable(flash_op_pending_out))
        else $error("out of range flash op had an effect");
    a_flash_issue: assert property (
        fl_go |=> flash_req_out && flash_op_pending_out ##1 !flash_req_out)
        else $error("flash op not issued in one cycle");
    a_pend_clear: assert property (
        flash_op_pending_out && flash_done_in && !fl_go |=> !flash_op_pending_out)
        else $error("pending not cleared on completion");
    a_fetch_block: assert property (
        flash_op_pending_out && from_flash_in && !flash_done_in |=> !instr_ready_out)
        else $error("flash fetch allowed while pending");
    a_read_result: assert property (
        fl_done && rd_op_q |=> data_q == $past(flash_rdata_in))
        else $error("flash read word not captured");
    a_inc_zero_flag: assert property (
        z_we |=> zero_flag_out == ($past(mval) == 8'hff))
        else $error("increment zero flag wrong");
    a_drop_no_exec: assert property (
        drop |=> $stable(acc_out) && $stable(zero_flag_out) && pc_out == 16'($past(pc_out) + 16'h0001))
        else $error("skipped word executed or counter stuck");
    a_dec_skip_decide: assert property (
        exec && is_dec |=> (state_q == INCDEC_S_DROP) == ($past(mval) == 8'h01))
        else $error("decrement skip decision wrong");
    a_inc_skip_decide: assert property (
        exec && skip_nz |=> (state_q == INCDEC_S_DROP) == ($past(mval) != 8'hff))
        else $error("increment skip decision wrong");
    a_inc_mem_back: assert property (
        exec && (cls == INCDEC_C_INC_FR || cls == INCDEC_C_INCSNZ_FR)
        |=> dmem[$past(maddr)] == 8'($past(mval) + 8'h01))
        else $error("increment result not written back");
    a_prog_word: assert property (
        fl_go && fop == INCDEC_F_PROG |=> flash_wdata_out == $past(data_q)
            && flash_op_out == INCDEC_F_PROG && flash_addr_out == $past(ptr_q))
        else $error("flash program word or address wrong");
    a_read_addr: assert property (
        fl_go && fop == INCDEC_F_READ |=> flash_addr_out == $past(ptr_q))
        else $error("flash read address wrong");
    a_flash_nonblock: assert property (
        fl_go && !from_flash_in |=> instr_ready_out)
        else $error("flash op blocked later instructions");

    c_long_skip: cover property (skip && cls == INCDEC_C_DECSZ_FR ##1 drop ##1 1'b1);
    c_flash_read: cover property (fl_go && fop == INCDEC_F_READ ##[1:20] fl_done);
    c_refused: cover property (fl_refused);
    c_irq: cover property (!irq_out ##1 irq_out);
    c_short_skip: cover property (skip && skip_nz ##1 drop);

endmodule : incdec_core

// ### test/incdec_flash_model.sv
// Behavioural program flash array on the far side of the flash link
`timescale 1ns/1ps

module incdec_flash_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic [1:0] op_in,
    input wire logic [23:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [7:0] delay_in,
    output logic done_out,
    output logic [15:0] rdata_out
);
    logic [15:0] arr [logic [23:0]];
    int cnt;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= 0;
            done_out <= 1'b0;
            rdata_out <= 16'h0000;
        end else begin
            done_out <= 1'b0;
            rdata_out <= ~rdata_out;
            if (req_in) begin
                cnt <= delay_in;
            end else if (cnt == 1) begin
                cnt <= 0;
                done_out <= 1'b1;
                case (op_in)
                    2'd0: for (int k = 0; k < 512; k += 2) arr[addr_in + 24'(k)] = 16'hffff;
                    2'd1: rdata_out <= arr.exists(addr_in) ? arr[addr_in] : 16'hffff;
                    default: arr[addr_in] = wdata_in;
                endcase
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : incdec_flash_model

// ### test/incdec_skip_and_flash_ops_bench.sv
// Self-checking bench for the increment/decrement and flash instruction unit
`timescale 1ns/1ps
`include "incdec_defs.svh"

module incdec_skip_and_flash_ops_bench import incdec_pkg::*; ;
    logic clk_in, rst_n_in, instr_valid_in, from_flash_in, psel, penable, pwrite;
    logic pready, pslverr, irq_out, instr_ready_out, zero_flag_out;
    logic flash_op_pending_out, flash_req_out, flash_done_in;
    logic [15:0] instr_in, flash_rdata_in, pc_out, flash_wdata_out, pc_exp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0] acc_out, fdelay;
    logic [1:0] flash_op_out;
    logic [23:0] flash_addr_out;
    logic [33:0] rdq [$];
    logic [25:0] fq [$];
    int n_mismatch, checked, ncyc;

    incdec_core u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .from_flash_in(from_flash_in), .instr_ready_out(instr_ready_out),
        .pc_out(pc_out), .acc_out(acc_out), .zero_flag_out(zero_flag_out),
        .flash_op_pending_out(flash_op_pending_out), .flash_req_out(flash_req_out),
        .flash_op_out(flash_op_out), .flash_addr_out(flash_addr_out),
        .flash_wdata_out(flash_wdata_out), .flash_done_in(flash_done_in),
        .flash_rdata_in(flash_rdata_in), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_out(irq_out));

    incdec_flash_model u_flash (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(flash_req_out),
        .op_in(flash_op_out), .addr_in(flash_addr_out), .wdata_in(flash_wdata_out),
        .delay_in(fdelay), .done_out(flash_done_in), .rdata_out(flash_rdata_in));

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic hang();
        n_mismatch++;
        $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        results();
    endtask : hang

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        int k;
        if (!w) rdq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
            if (k > 20) hang();
        end while (pready !== 1'b1);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {2'b00, e});
    endtask : rd

    task automatic poll();
        for (int k = 0; k < 60; k++) begin
            apb(1'b0, `INCDEC_REG_XSET, 32'h0, 34'h2_0000_0000);
            if (rdv[0] === 1'b0) return;
        end
        hang();
    endtask : poll

    task automatic run(input logic [15:0] w [3], input int n);
        int k;
        ncyc = 0;
        for (int i = 0; i < n; i++) begin
            instr_valid_in <= 1'b1;
            instr_in <= w[i];
            k = 0;
            do begin
                @(posedge clk_in);
                ncyc++;
                k++;
                if (k > 20) hang();
            end while (instr_ready_out !== 1'b1);
        end
        instr_valid_in <= 1'b0;
        @(posedge clk_in);
    endtask : run

    always @(posedge clk_in) begin
        logic [33:0] e;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (rdq.size() == 0) hang();
            e = rdq.pop_front();
            if (!e[33]) chk({pslverr, prdata}, e[32:0]);
        end
        if (flash_req_out === 1'b1) begin
            if (fq.size() == 0) hang();
            chk({flash_op_out, flash_addr_out}, fq.pop_front());
        end
    end

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    initial begin
        logic [6:0] ops [6];
        logic [15:0] fops [3];
        logic [7:0] v, r, acc0, edv [3];
        logic [8:0] a;
        logic [6:0] opc;
        logic z0, skip;
        int s;
        ops = '{`INCDEC_OPC_DECSZ_FR, `INCDEC_OPC_DECSZ_W, `INCDEC_OPC_INC_FR,
                `INCDEC_OPC_INC_W, `INCDEC_OPC_INCSNZ_FR, `INCDEC_OPC_INCSNZ_W};
        fops = '{`INCDEC_OPC_ERASE, `INCDEC_OPC_FREAD, `INCDEC_OPC_FPROG};
        edv = '{8'h00, 8'h01, 8'hff};
        rst_n_in = 1'b0;
        instr_valid_in = 1'b0;
        instr_in = 16'h0000;
        from_flash_in = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fdelay = 8'h0c;
        pc_exp = 16'h0000;
        s = $urandom(62);
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        rd(`INCDEC_REG_ACC, 32'h0);
        rd(`INCDEC_REG_PC, 32'h0);
        apb(1'b0, 12'h020, 32'h0, 34'h1_0000_0000);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            opc = ops[i % 6];
            v = (i < 18) ? edv[i / 6] : 8'($urandom);
            a = 9'($urandom_range(0, 510));
            acc0 = 8'($urandom);
            z0 = 1'($urandom);
            wr(12'h800 + {1'b0, a, 2'b00}, {24'h0, v});
            wr(12'hffc, 32'h80);
            wr(`INCDEC_REG_ACC, {24'h0, acc0});
            wr(`INCDEC_REG_STATUS, {31'h0, z0});
            r = opc[1] ? v - 8'h01 : v + 8'h01;
            skip = opc[1] ? (r == 8'h00) : (opc[5] && r != 8'h00);
            run('{{opc, a}, {`INCDEC_OPC_DECSZ_FR, 9'h1ff}, 16'h0000}, 3);
            pc_exp += 16'h0003;
            chk(ncyc, 3 + int'(skip && opc == `INCDEC_OPC_DECSZ_FR));
            rd(12'h800 + {1'b0, a, 2'b00}, opc[0] ? r : v);
            rd(`INCDEC_REG_ACC, opc[0] ? acc0 : r);
            rd(`INCDEC_REG_STATUS, (opc[5:1] == 5'b01010) ? (r == 8'h00) : z0);
            rd(12'hffc, skip ? 32'h80 : 32'h7f);
            rd(`INCDEC_REG_PC, pc_exp);
            chk(acc_out, opc[0] ? acc0 : r);
            chk(zero_flag_out, (opc[5:1] == 5'b01010) ? (r == 8'h00) : z0);
            chk(pc_out, pc_exp);
        end
        $display("test arithmetic done");
        wr(`INCDEC_REG_PTR, 32'h012344);
        wr(`INCDEC_REG_DATA, 32'hbeef);
        fq.push_back({2'd2, 24'h012344});
        run('{`INCDEC_OPC_FPROG, 16'h0, 16'h0}, 1);
        chk(flash_op_pending_out, 1);
        chk(flash_wdata_out, 16'hbeef);
        rd(`INCDEC_REG_XSET, 32'h1);
        run('{{`INCDEC_OPC_INC_W, 9'h1ff}, 16'h0, 16'h0}, 1);
        chk(ncyc, 1);
        from_flash_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk(instr_ready_out, 0);
        from_flash_in <= 1'b0;
        poll();
        chk(flash_op_pending_out, 0);
        fdelay <= 8'h01;
        wr(`INCDEC_REG_DATA, 32'h0);
        fq.push_back({2'd1, 24'h012344});
        run('{`INCDEC_OPC_FREAD, 16'h0, 16'h0}, 1);
        poll();
        rd(`INCDEC_REG_DATA, 32'hbeef);
        wr(`INCDEC_REG_PTR, 32'h012377);
        fq.push_back({2'd0, 24'h012300});
        run('{`INCDEC_OPC_ERASE, 16'h0, 16'h0}, 1);
        poll();
        wr(`INCDEC_REG_PTR, 32'h012344);
        fq.push_back({2'd1, 24'h012344});
        run('{`INCDEC_OPC_FREAD, 16'h0, 16'h0}, 1);
        poll();
        rd(`INCDEC_REG_DATA, 32'hffff);
        $display("test flash done");
        wr(`INCDEC_REG_ISTAT, 32'h7);
        wr(`INCDEC_REG_PTR, 32'h020000);
        foreach (fops[i]) begin
            run('{fops[i], 16'h0, 16'h0}, 1);
            rd(`INCDEC_REG_XSET, 32'h0);
        end
        rd(`INCDEC_REG_ISTAT, 32'h2);
        wr(`INCDEC_REG_ISTAT, 32'h7);
        wr(`INCDEC_REG_PTR, 32'h012344);
        fq.push_back({2'd1, 24'h012344});
        run('{`INCDEC_OPC_FREAD, 16'h0, 16'h0}, 1);
        poll();
        rd(`INCDEC_REG_ISTAT, 32'h1);
        wr(`INCDEC_REG_IMASK, 32'h1);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1);
        wr(`INCDEC_REG_IMASK, 32'h0);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 0);
        wr(`INCDEC_REG_IMASK, 32'h1);
        wr(`INCDEC_REG_ISTAT, 32'h1);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 0);
        rd(`INCDEC_REG_ISTAT, 32'h0);
        $display("test interrupt done");
        results();
    end
endmodule : incdec_skip_and_flash_ops_bench
